// ---- logic/syc_pkg.sv ----
package syc_pkg;

    // ========================================
    // Bus decode
    localparam int SYC_ADDR_W = 8;
    localparam logic [SYC_ADDR_W-1:0] SYC_OFF_SYSCTL = 8'h00;
    localparam logic [SYC_ADDR_W-1:0] SYC_OFF_MODE_RB = 8'h04;
    localparam logic [SYC_ADDR_W-1:0] SYC_OFF_FLASH_BASE = 8'h10;
    localparam logic [SYC_ADDR_W-1:0] SYC_OFF_STRIDE = 8'h04;
    localparam int SYC_FLASH_REGS = 2;
    localparam logic [2:0] SYC_HSIZE_WORD = 3'h2;
    localparam logic SYC_HRESP_OKAY = 1'h0;

    // ========================================
    // System control register layout
    localparam int SYC_REG_W = 16;
    localparam int SYC_BIT_MULTIPLY_ACCUMULATE_SATURATION = 13;
    localparam int SYC_BIT_ONCHIP_MEMORY_ENABLE = 8;
    localparam int SYC_BIT_FLASH_CTRL_REG_ACCESS_ENABLE = 7;
    localparam logic [SYC_REG_W-1:0] SYC_SYSCTL_WMASK = 16'h2180;
    localparam logic [SYC_REG_W-1:0] SYC_SYSCTL_ONES = 16'hD403;
    localparam logic [SYC_REG_W-1:0] SYC_SYSCTL_ZEROS = 16'h0A7C;
    localparam logic [SYC_REG_W-1:0] SYC_SYSCTL_RESET = 16'h0100;
    localparam logic [SYC_REG_W-1:0] SYC_FLASH_RESET = 16'h0000;

    // ========================================
    // Mode readback layout
    localparam logic [3:0] SYC_RB_FIXED_NIBBLE = 4'h5;
    localparam logic [3:0] SYC_MDS_MODE1 = 4'hD;
    localparam logic [3:0] SYC_MDS_MODE2 = 4'hC;
    localparam logic [3:0] SYC_MDS_MODE3 = 4'h4;
    localparam logic [3:0] SYC_MDS_NONE = 4'h0;
    localparam logic [1:0] SYC_PINS_MODE1 = 2'h1;
    localparam logic [1:0] SYC_PINS_MODE2 = 2'h2;
    localparam logic [1:0] SYC_PINS_MODE3 = 2'h3;

    typedef enum logic [3:0] {
        SYC_MODE_USER_BOOT = 4'h1,
        SYC_MODE_BOOT = 4'h2,
        SYC_MODE_ADVANCED = 4'h4,
        SYC_MODE_ILLEGAL = 4'h8
    } syc_mode_e;

    typedef struct packed {
        logic [SYC_ADDR_W-1:0] addr;
        logic write;
    } syc_ahb_req_s;

    typedef logic [SYC_REG_W-1:0] syc_word_t;

endpackage

// ---- logic/syc_sync.sv ----
`timescale 1ns/1ns
// ========================================
// Two-stage synchroniser for pin levels
module syc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // No reset: pins are sampled during reset so the mode is valid at release
    always_ff @(posedge clk) begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
endmodule

// ---- logic/syc_top.sv ----
`timescale 1ns/1ns
// How it works
// R1 - System control bits 11 and 9 always read as zero and software writes zero to them.
// R2 - System control bits 10, 1 and 0 always read as one and software writes one to them.
// R3 - System control bits 6 down to 2 always read as zero and software writes zero to them.
// R4 - Bit 8 enables the on-chip RAM when one and disables it when zero, starting at one.
// R5 - The RAM enable bit returns to one when the chip leaves reset.
// R6 - Software never clears the RAM enable bit while an on-chip RAM access is under way.
// R7 - Bit 7 opens reads and writes of the flash control registers when one, blocks them when zero, starts at zero.
// R8 - While flash register access is blocked the flash control registers keep their contents.
// R9 - On a part without flash, software writes zero to the flash register access bit.
// R10 - Mode 1 is user boot mode and acts as mode 3 apart from flash programming and erasing.
// R11 - Mode 2 is boot mode and acts as mode 3 apart from flash programming and erasing.
// R12 - Mode 3 is advanced single-chip mode with a 16 Mbyte space and on-chip ROM enabled.
// R13 - Mode pins 01, 10, 11 pick modes 1, 2, 3, with mode readback 1101, 1100 and 0100.
// R14 - Bit 13 picks saturating multiply-accumulate when one, non-saturating when zero, reset zero.
// R15 - The system control register is 16 bits and bits 15, 14 and 12 read as fixed ones.
module syc_top
    import syc_pkg::*;
#(
    parameter int FLASH_REGS = SYC_FLASH_REGS
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic MODE_PIN_HIGH,
    input wire logic MODE_PIN_LOW,
    output logic ONCHIP_MEMORY_ENABLE,
    output logic FLASH_CTRL_REG_ACCESS_ENABLE,
    output logic MULTIPLY_ACCUMULATE_SATURATION,
    output logic MODE_USER_BOOT,
    output logic MODE_BOOT,
    output logic MODE_ADVANCED,
    output logic ONCHIP_ROM_ENABLE,
    output logic [SYC_REG_W-1:0] FLASH_CTRL_REG0
);

    // ========================================
    // AHB-Lite address and data phase
    wire addr_phase = HSEL && HTRANS[1] && HREADY;
    wire word_write = HWRITE && (HSIZE == SYC_HSIZE_WORD);
    wire [SYC_ADDR_W-1:0] haddr_lo = HADDR[SYC_ADDR_W-1:0];

    syc_ahb_req_s req_r;
    logic wr_pend_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            wr_pend_r <= 1'b0;
            req_r <= '0;
        end else begin
            wr_pend_r <= addr_phase && word_write;
            if (addr_phase) begin
                req_r.addr <= haddr_lo;
                req_r.write <= HWRITE;
            end
        end
    end

    // Zero wait states, and every transfer answers OKAY
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            hreadyout_r <= 1'b1;
            hresp_r <= SYC_HRESP_OKAY;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= SYC_HRESP_OKAY;
        end
    end

    assign HREADYOUT = hreadyout_r;
    assign HRESP = hresp_r;

    // ========================================
    // System control register
    // Only the three live bits are stored; reserved bits are constants.
    syc_word_t sysctl_r;
    syc_word_t sysctl_nxt;
    wire wr_sysctl = wr_pend_r && (req_r.addr == SYC_OFF_SYSCTL);

    assign sysctl_nxt = wr_sysctl ? (HWDATA[SYC_REG_W-1:0] & SYC_SYSCTL_WMASK) : sysctl_r; // R1 R2 R3

    // Reset release reloads RAM enable high, flash access low, MAC mode low
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sysctl_r <= SYC_SYSCTL_RESET; // R5 R14
        end else begin
            sysctl_r <= sysctl_nxt;
        end
    end

    wire flash_en = sysctl_r[SYC_BIT_FLASH_CTRL_REG_ACCESS_ENABLE];
    wire [SYC_REG_W-1:0] sysctl_rd_nxt = (sysctl_nxt & SYC_SYSCTL_WMASK) | SYC_SYSCTL_ONES; // R15

    assign ONCHIP_MEMORY_ENABLE = sysctl_r[SYC_BIT_ONCHIP_MEMORY_ENABLE]; // R4
    assign FLASH_CTRL_REG_ACCESS_ENABLE = sysctl_r[SYC_BIT_FLASH_CTRL_REG_ACCESS_ENABLE]; // R7
    assign MULTIPLY_ACCUMULATE_SATURATION = sysctl_r[SYC_BIT_MULTIPLY_ACCUMULATE_SATURATION]; // R14

    // ========================================
    // Flash control register window
    // Access bit gates both directions; blocked writes are dropped, contents held
    syc_word_t flash_r [FLASH_REGS];
    syc_word_t flash_nxt [FLASH_REGS];
    logic [SYC_ADDR_W-1:0] flash_off [FLASH_REGS];
    logic [FLASH_REGS-1:0] flash_hit;
    logic [FLASH_REGS-1:0] flash_wr;

    genvar gi;
    generate
        for (gi = 0; gi < FLASH_REGS; gi++) begin : g_flash
            assign flash_off[gi] = SYC_OFF_FLASH_BASE + SYC_ADDR_W'(gi * SYC_OFF_STRIDE);
            assign flash_hit[gi] = (haddr_lo == flash_off[gi]);
            assign flash_wr[gi] = wr_pend_r && flash_en && (req_r.addr == flash_off[gi]); // R7 R8
            assign flash_nxt[gi] = flash_wr[gi] ? HWDATA[SYC_REG_W-1:0] : flash_r[gi]; // R8

            always_ff @(posedge MCLK) begin
                if (RESET) begin
                    flash_r[gi] <= SYC_FLASH_RESET;
                end else begin
                    flash_r[gi] <= flash_nxt[gi];
                end
            end
        end
    endgenerate

    assign FLASH_CTRL_REG0 = flash_r[0];

    // ========================================
    // Mode pins and mode capture
    logic [1:0] pins_s;
    syc_mode_e mode_r;
    syc_mode_e mode_dec;
    logic mode_valid_r;
    logic rom_en_r;

    syc_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk(MCLK),
        .async_in({MODE_PIN_HIGH, MODE_PIN_LOW}),
        .sync_out(pins_s)
    );

    always_comb begin
        case (pins_s)
            SYC_PINS_MODE1: mode_dec = SYC_MODE_USER_BOOT; // R10 R13
            SYC_PINS_MODE2: mode_dec = SYC_MODE_BOOT; // R11 R13
            SYC_PINS_MODE3: mode_dec = SYC_MODE_ADVANCED; // R12 R13
            default: mode_dec = SYC_MODE_ILLEGAL;
        endcase
    end

    // Pins caught once, at the first edge after reset release
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            mode_valid_r <= 1'b0;
            mode_r <= SYC_MODE_ILLEGAL;
            rom_en_r <= 1'b0;
        end else if (!mode_valid_r) begin
            mode_valid_r <= 1'b1;
            mode_r <= mode_dec;
            rom_en_r <= (mode_dec != SYC_MODE_ILLEGAL); // R12
        end
    end

    assign MODE_USER_BOOT = mode_r[0];
    assign MODE_BOOT = mode_r[1];
    assign MODE_ADVANCED = mode_r[2];
    assign ONCHIP_ROM_ENABLE = rom_en_r;

    logic [3:0] mds;
    always_comb begin
        case (mode_r)
            SYC_MODE_USER_BOOT: mds = SYC_MDS_MODE1; // R13
            SYC_MODE_BOOT: mds = SYC_MDS_MODE2; // R13
            SYC_MODE_ADVANCED: mds = SYC_MDS_MODE3; // R13
            default: mds = SYC_MDS_NONE;
        endcase
    end

    wire [SYC_REG_W-1:0] mode_rb = {SYC_RB_FIXED_NIBBLE, mds, SYC_RB_FIXED_NIBBLE, mds};

    // ========================================
    // Read data
    // Read mux looks at next-state values so a read right behind a write sees it
    logic [SYC_REG_W-1:0] rd_word;
    always_comb begin
        rd_word = '0;
        if (haddr_lo == SYC_OFF_SYSCTL) begin
            rd_word = sysctl_rd_nxt;
        end else if (haddr_lo == SYC_OFF_MODE_RB) begin
            rd_word = mode_rb;
        end
        for (int i = 0; i < FLASH_REGS; i++) begin
            if (flash_hit[i] && sysctl_nxt[SYC_BIT_FLASH_CTRL_REG_ACCESS_ENABLE]) begin
                rd_word = flash_nxt[i]; // R7
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            hrdata_r <= '0;
        end else if (addr_phase && !HWRITE) begin
            hrdata_r <= {16'h0000, rd_word};
        end
    end

    assign HRDATA = hrdata_r;

    // ========================================
    // Checks
    sequence s_read_sysctl;
        addr_phase && !HWRITE && (haddr_lo == SYC_OFF_SYSCTL);
    endsequence

    sequence s_write_sysctl;
        addr_phase && word_write && (HADDR[SYC_ADDR_W-1:0] == SYC_OFF_SYSCTL);
    endsequence

    property p_read_fixed(logic [15:0] mask, logic [15:0] val);
        @(posedge MCLK) disable iff (RESET)
        s_read_sysctl |=> ((HRDATA[15:0] & mask) == val);
    endproperty

    chk_rsv_bits_low: assert property (p_read_fixed(16'h0A00, 16'h0000)) // R1
        else $error("bits 11 or 9 read as one");

    chk_rsv_bits_high: assert property (p_read_fixed(16'h0403, 16'h0403)) // R2
        else $error("bits 10, 1 or 0 read as zero");

    chk_rsv_span_low: assert property (p_read_fixed(16'h007C, 16'h0000)) // R3
        else $error("bits 6 to 2 read as nonzero");

    chk_top_fixed_ones: assert property (p_read_fixed(16'hD000, 16'hD000)) // R15
        else $error("bits 15, 14, 12 not read as one");

    chk_ram_enable_write: assert property (@(posedge MCLK) disable iff (RESET)
        s_write_sysctl ##1 1'b1 |=> (ONCHIP_MEMORY_ENABLE == $past(HWDATA[8]))) // R4
        else $error("RAM enable did not follow write");

    chk_ram_enable_reset: assert property (@(posedge MCLK)
        $fell(RESET) |-> ONCHIP_MEMORY_ENABLE && !FLASH_CTRL_REG_ACCESS_ENABLE) // R5
        else $error("enable bits wrong at reset release");

    chk_multiply_accumulate_saturation_reset: assert property (@(posedge MCLK)
        $fell(RESET) |-> !MULTIPLY_ACCUMULATE_SATURATION) // R14
        else $error("MAC saturation not zero after reset");

    chk_multiply_accumulate_saturation_write: assert property (@(posedge MCLK) disable iff (RESET)
        s_write_sysctl ##1 1'b1 |=> (MULTIPLY_ACCUMULATE_SATURATION == $past(HWDATA[13]))) // R14
        else $error("MAC saturation did not follow write");

    chk_flash_hold: assert property (@(posedge MCLK) disable iff (RESET)
        !FLASH_CTRL_REG_ACCESS_ENABLE |=> $stable(FLASH_CTRL_REG0)) // R8
        else $error("flash register changed while access blocked");

    chk_flash_write: assert property (@(posedge MCLK) disable iff (RESET)
        wr_pend_r && flash_en && (req_r.addr == SYC_OFF_FLASH_BASE)
        |=> (FLASH_CTRL_REG0 == $past(HWDATA[15:0]))) // R7
        else $error("enabled flash register write lost");

    chk_mode_one: assert property (@(posedge MCLK) disable iff (RESET)
        !mode_valid_r && (pins_s == SYC_PINS_MODE1)
        |=> MODE_USER_BOOT && !MODE_BOOT && !MODE_ADVANCED && ONCHIP_ROM_ENABLE) // R10
        else $error("pins 01 did not give mode 1");

    chk_mode_two: assert property (@(posedge MCLK) disable iff (RESET)
        !mode_valid_r && (pins_s == SYC_PINS_MODE2)
        |=> MODE_BOOT && !MODE_USER_BOOT && !MODE_ADVANCED && ONCHIP_ROM_ENABLE) // R11
        else $error("pins 10 did not give mode 2");

    chk_mode_three: assert property (@(posedge MCLK) disable iff (RESET)
        !mode_valid_r && (pins_s == SYC_PINS_MODE3)
        |=> MODE_ADVANCED && !MODE_USER_BOOT && !MODE_BOOT && ONCHIP_ROM_ENABLE) // R12
        else $error("pins 11 did not give mode 3");

    chk_mode_readback: assert property (@(posedge MCLK) disable iff (RESET)
        addr_phase && !HWRITE && (haddr_lo == SYC_OFF_MODE_RB) && MODE_BOOT
        |=> (HRDATA[11:8] == SYC_MDS_MODE2) && (HRDATA[3:0] == SYC_MDS_MODE2)) // R13
        else $error("mode readback wrong for mode 2");

endmodule

// ---- testbench/syc_top_test.sv ----
`timescale 1ns/1ns
module syc_top_test
    import syc_pkg::*;
;
    typedef struct packed {
        logic [15:0] wval;
        logic [15:0] rval;
        logic [2:0] outs;
    } syc_row_s;
    typedef struct packed {
        logic [1:0] pins;
        logic [3:0] code;
        logic [2:0] hot;
    } syc_mode_row_s;

    logic MCLK, RESET, HSEL, HWRITE, HREADYOUT, HRESP, MODE_PIN_HIGH, MODE_PIN_LOW;
    logic [31:0] HADDR, HWDATA, HRDATA, rdata;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic ram_en, flash_en, mac_sat, m_user, m_boot, m_adv, rom_en;
    logic [SYC_REG_W-1:0] flash0;
    int n_fail, compares;

    // ========================================
    // Ordinary cases: write system control, read it back
    syc_row_s rows [6] = '{
        '{16'h0000, 16'hD403, 3'b000},
        '{16'h0E7C, 16'hD403, 3'b000},
        '{16'h2000, 16'hF403, 3'b001},
        '{16'h0080, 16'hD483, 3'b010},
        '{16'h0100, 16'hD503, 3'b100},
        '{16'hFFFF, 16'hF583, 3'b111}
    };
    syc_mode_row_s modes [4] = '{
        '{2'h1, 4'hD, 3'b100},
        '{2'h2, 4'hC, 3'b010},
        '{2'h3, 4'h4, 3'b001},
        '{2'h0, 4'h0, 3'b000}
    };

    syc_top u_dut (
        .MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HRDATA(HRDATA), .MODE_PIN_HIGH(MODE_PIN_HIGH), .MODE_PIN_LOW(MODE_PIN_LOW),
        .ONCHIP_MEMORY_ENABLE(ram_en), .FLASH_CTRL_REG_ACCESS_ENABLE(flash_en),
        .MULTIPLY_ACCUMULATE_SATURATION(mac_sat), .MODE_USER_BOOT(m_user), .MODE_BOOT(m_boot),
        .MODE_ADVANCED(m_adv), .ONCHIP_ROM_ENABLE(rom_en), .FLASH_CTRL_REG0(flash0)
    );

    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    // ========================================
    // Compare and closing tasks
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================
    // Bus master, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd, input logic [2:0] sz);
        int n;
        n = 0;
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {24'h000000, a};
        HSIZE <= sz;
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1 && n < 100) begin
            @(posedge MCLK);
            n++;
        end
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {16'h0000, wd};
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1 && n < 200) begin
            @(posedge MCLK);
            n++;
        end
        // A wait that runs out is a failure, not a silent pass
        if (n >= 100) begin
            n_fail++;
        end
        rdata = HRDATA;
        cmp_bit(HRESP, SYC_HRESP_OKAY);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d, SYC_HSIZE_WORD);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 16'h0000, SYC_HSIZE_WORD);
        cmp_word(rdata, exp);
    endtask

    task automatic do_reset;
        RESET <= 1'b1;
        repeat (20) @(posedge MCLK);
        RESET <= 1'b0;
        repeat (3) @(posedge MCLK);
    endtask

    initial begin
        repeat (5000) @(posedge MCLK);
        n_fail++;
        complete_run();
    end

    initial begin
        n_fail = 0;
        compares = 0;
        RESET = 1'b1;
        HSEL = 1'b0;
        HADDR = 32'h00000000;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = SYC_HSIZE_WORD;
        HWDATA = 32'h00000000;
        MODE_PIN_HIGH = 1'b1;
        MODE_PIN_LOW = 1'b1;
        repeat (10) @(posedge MCLK);
        cmp_word({HRDATA[31:1], HREADYOUT}, 32'h00000001);
        cmp_word({16'h0000, flash0}, 32'h00000000);
        repeat (10) @(posedge MCLK);
        RESET <= 1'b0;
        repeat (3) @(posedge MCLK);
        rchk(SYC_OFF_SYSCTL, 32'h0000D503);
        rchk(SYC_OFF_MODE_RB, 32'h00005454);
        cmp_word({29'h0, m_user, m_boot, m_adv}, 32'h00000001);
        cmp_bit(rom_en, 1'b1);
        foreach (rows[i]) begin
            wreg(SYC_OFF_SYSCTL, rows[i].wval);
            rchk(SYC_OFF_SYSCTL, {16'h0000, rows[i].rval});
            cmp_word({29'h0, ram_en, flash_en, mac_sat}, {29'h0, rows[i].outs});
        end
        // ========================================
        // Awkward cases
        bus(1'b1, SYC_OFF_SYSCTL, 16'h0000, 3'h0);
        rchk(SYC_OFF_SYSCTL, 32'h0000F583);
        wreg(SYC_OFF_FLASH_BASE, 16'hA5C3);
        rchk(SYC_OFF_FLASH_BASE, 32'h0000A5C3);
        cmp_word({16'h0000, flash0}, 32'h0000A5C3);
        wreg(SYC_OFF_SYSCTL, 16'h0503);
        rchk(SYC_OFF_FLASH_BASE, 32'h00000000);
        wreg(SYC_OFF_FLASH_BASE, 16'h1234);
        cmp_word({16'h0000, flash0}, 32'h0000A5C3);
        wreg(SYC_OFF_SYSCTL, 16'h0583);
        rchk(SYC_OFF_FLASH_BASE, 32'h0000A5C3);
        rchk(8'h40, 32'h00000000);
        wreg(SYC_OFF_MODE_RB, 16'hFFFF);
        rchk(SYC_OFF_MODE_RB, 32'h00005454);
        wreg(SYC_OFF_SYSCTL, 16'h2000);
        // Each reset recaptures the pins; later pin moves must not leak through
        foreach (modes[i]) begin
            MODE_PIN_HIGH <= modes[i].pins[1];
            MODE_PIN_LOW <= modes[i].pins[0];
            do_reset();
            cmp_word({29'h0, ram_en, flash_en, mac_sat}, 32'h00000004);
            rchk(SYC_OFF_MODE_RB, {16'h0000, 4'h5, modes[i].code, 4'h5, modes[i].code});
            cmp_word({29'h0, m_user, m_boot, m_adv}, {29'h0, modes[i].hot});
            if (modes[i].code !== 4'h0) begin
                cmp_bit(rom_en, 1'b1);
            end
            MODE_PIN_HIGH <= ~modes[i].pins[1];
            MODE_PIN_LOW <= ~modes[i].pins[0];
            repeat (6) @(posedge MCLK);
            cmp_word({29'h0, m_user, m_boot, m_adv}, {29'h0, modes[i].hot});
        end
        complete_run();
    end
endmodule
